// [rtl/dbc_band_control.sv]
// Purpose: band control register, channel enables and interrupt requests
// Assumes: apb slave with zero wait states, activation sources on ref_clk
// Notes: two channels in full address mode
`timescale 1ns/1ps
module dbc_band_control (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // activation sources and nmi
  input wire logic [15:0] act_req,
  input wire logic nmi_evt,
  // channel 0 datapath
  output logic ch0_xfer_go,
  input wire logic ch0_xfer_done,
  output logic [15:0] ch0_act_clr,
  output logic ch0_irq_pass,
  // channel 1 datapath
  output logic ch1_xfer_go,
  input wire logic ch1_xfer_done,
  output logic [15:0] ch1_act_clr,
  output logic ch1_irq_pass,
  // interrupt requests
  output logic ch0_end_irq,
  output logic ch0_break_irq,
  output logic ch1_end_irq,
  output logic ch1_break_irq
);
  logic [7:0] band_control;
  logic [7:0] next_band;
  logic [3:0] arm;
  logic [8:0] source_cfg;
  logic [15:0] ch0_count;
  logic [15:0] ch1_count;
  logic ch0_finished;
  logic ch1_finished;
  logic ch0_busy;
  logic ch1_busy;
  logic setup;
  logic fire;
  logic wr_band;
  logic rd_band;
  logic wr_source;
  logic wr_count;
  logic [31:0] count_word;
  logic [31:0] count_merged;
  logic [31:0] source_merged;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == dbc_pkg::BAND_CONTROL_ADDR) || (a == dbc_pkg::STATUS_ADDR) ||
              (a == dbc_pkg::SOURCE_ADDR) || (a == dbc_pkg::COUNT_ADDR);
  endfunction : addr_ok

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // apb decode
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign fire = psel & penable;
  assign wr_band = fire & pwrite & (paddr == dbc_pkg::BAND_CONTROL_ADDR) & pstrb[0];
  assign rd_band = fire & ~pwrite & (paddr == dbc_pkg::BAND_CONTROL_ADDR);
  assign wr_source = fire & pwrite & (paddr == dbc_pkg::SOURCE_ADDR);
  assign wr_count = fire & pwrite & (paddr == dbc_pkg::COUNT_ADDR);
  assign count_word = {ch1_count, ch0_count};
  assign count_merged = merge(count_word, pwdata, pstrb);
  assign source_merged = merge({23'h000000, source_cfg}, pwdata, pstrb);

  // band control next value
  always_comb begin
    next_band = band_control;
    if (wr_band) begin
      for (int i = 0; i < 4; i++) begin
        next_band[i] = pwdata[i];
        next_band[dbc_pkg::ENABLE_LSB + i] = pwdata[dbc_pkg::ENABLE_LSB + i] &
            (band_control[dbc_pkg::ENABLE_LSB + i] | arm[i]);
      end
    end
    // hardware clears win over a software set in the same cycle
    if (ch0_finished) begin
      next_band[dbc_pkg::CH0_XE] = 1'b0;
    end
    if (ch1_finished) begin
      next_band[dbc_pkg::CH1_XE] = 1'b0;
    end
    if (nmi_evt && source_cfg[dbc_pkg::CH0_BURST] && ch0_busy) begin
      next_band[dbc_pkg::CH0_ME] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      band_control <= dbc_pkg::BAND_CONTROL_RESET;
    end else begin
      band_control <= next_band;
    end
  end

  // an enable is armed only by a read that returned it as 0
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arm <= 4'h0;
    end else if (rd_band) begin
      arm <= ~prdata[dbc_pkg::CH1_ME:dbc_pkg::CH0_XE];
    end else if (wr_band) begin
      arm <= 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      source_cfg <= dbc_pkg::SOURCE_RESET;
    end else if (wr_source) begin
      source_cfg <= source_merged[8:0];
    end
  end

  // read data latched in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~addr_ok(paddr);
      case (paddr)
        dbc_pkg::BAND_CONTROL_ADDR: begin
          prdata <= {24'h000000, band_control};
        end
        dbc_pkg::STATUS_ADDR: begin
          prdata <= {24'h000000, ch1_busy, ch0_busy, ch1_irq_pass, ch0_irq_pass,
                     ch1_break_irq, ch1_end_irq, ch0_break_irq, ch0_end_irq};
        end
        dbc_pkg::SOURCE_ADDR: begin
          prdata <= {23'h000000, source_cfg};
        end
        dbc_pkg::COUNT_ADDR: begin
          prdata <= count_word;
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end

  dbc_channel u_ch0 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .xfer_enable(band_control[dbc_pkg::CH0_XE]),
    .master_enable(band_control[dbc_pkg::CH0_ME]),
    .src_sel(source_cfg[dbc_pkg::CH0_SRC_LSB +: 4]),
    .cnt_load(wr_count & (pstrb[1:0] != 2'b00)),
    .cnt_wdata(count_merged[dbc_pkg::CH0_CNT_LSB +: 16]),
    .act_req(act_req),
    .act_clr(ch0_act_clr),
    .irq_pass(ch0_irq_pass),
    .xfer_go(ch0_xfer_go),
    .xfer_done(ch0_xfer_done),
    .count(ch0_count),
    .finished(ch0_finished),
    .busy(ch0_busy)
  );

  dbc_channel u_ch1 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .xfer_enable(band_control[dbc_pkg::CH1_XE]),
    .master_enable(band_control[dbc_pkg::CH1_ME]),
    .src_sel(source_cfg[dbc_pkg::CH1_SRC_LSB +: 4]),
    .cnt_load(wr_count & (pstrb[3:2] != 2'b00)),
    .cnt_wdata(count_merged[dbc_pkg::CH1_CNT_LSB +: 16]),
    .act_req(act_req),
    .act_clr(ch1_act_clr),
    .irq_pass(ch1_irq_pass),
    .xfer_go(ch1_xfer_go),
    .xfer_done(ch1_xfer_done),
    .count(ch1_count),
    .finished(ch1_finished),
    .busy(ch1_busy)
  );

  dbc_irq u_irq0 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .xfer_enable(band_control[dbc_pkg::CH0_XE]),
    .master_enable(band_control[dbc_pkg::CH0_ME]),
    .end_irq_enable(band_control[dbc_pkg::CH0_END_IE]),
    .break_irq_enable(band_control[dbc_pkg::CH0_BRK_IE]),
    .end_irq(ch0_end_irq),
    .break_irq(ch0_break_irq)
  );

  dbc_irq u_irq1 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .xfer_enable(band_control[dbc_pkg::CH1_XE]),
    .master_enable(band_control[dbc_pkg::CH1_ME]),
    .end_irq_enable(band_control[dbc_pkg::CH1_END_IE]),
    .break_irq_enable(band_control[dbc_pkg::CH1_BRK_IE]),
    .end_irq(ch1_end_irq),
    .break_irq(ch1_break_irq)
  );
endmodule : dbc_band_control

// [rtl/dbc_pkg.sv]
// Purpose: shared constants for the dma band control block
// Assumes: apb register map with 8-bit byte addresses
// Notes: band control holds the low byte of the band control word
package dbc_pkg;
  // register byte addresses
  localparam logic [7:0] BAND_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] SOURCE_ADDR = 8'h08;
  localparam logic [7:0] COUNT_ADDR = 8'h0C;

  // band control field positions
  localparam int CH0_END_IE = 0;
  localparam int CH0_BRK_IE = 1;
  localparam int CH1_END_IE = 2;
  localparam int CH1_BRK_IE = 3;
  localparam int CH0_XE = 4;
  localparam int CH0_ME = 5;
  localparam int CH1_XE = 6;
  localparam int CH1_ME = 7;
  localparam int ENABLE_LSB = 4;
  localparam logic [7:0] BAND_CONTROL_RESET = 8'h00;

  // source register fields
  localparam int CH0_SRC_LSB = 0;
  localparam int CH1_SRC_LSB = 4;
  localparam int CH0_BURST = 8;
  localparam logic [8:0] SOURCE_RESET = 9'h000;

  // count register fields
  localparam int CH0_CNT_LSB = 0;
  localparam int CH1_CNT_LSB = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_LAST = 16'h0001;

  // activation sources that are internal interrupts
  localparam logic [15:0] INTERNAL_SRC_MASK = 16'h00FF;

  typedef enum logic [1:0] {
    DBC_IDLE = 2'b00,
    DBC_WAIT = 2'b01,
    DBC_XFER = 2'b10
  } dbc_chan_state_t;
endpackage : dbc_pkg

// [rtl/dbc_irq.sv]
// Purpose: end and break interrupt request levels of one channel
// Assumes: enables come from the band control register
// Notes: levels are registered, one cycle after their cause
`timescale 1ns/1ps
module dbc_irq (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // channel enables
  input wire logic xfer_enable,
  input wire logic master_enable,
  input wire logic end_irq_enable,
  input wire logic break_irq_enable,
  // requests
  output logic end_irq,
  output logic break_irq
);
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      end_irq <= 1'b0;
    end else begin
      end_irq <= end_irq_enable & ~xfer_enable;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      break_irq <= 1'b0;
    end else begin
      break_irq <= break_irq_enable & ~master_enable;
    end
  end
endmodule : dbc_irq

// [rtl/dbc_channel.sv]
// Purpose: request gating, transfer sequencing and count of one channel
// Assumes: activation requests are levels on ref_clk, held until cleared
// Notes: one transfer per taken request; finished pulses on the last one
`timescale 1ns/1ps
module dbc_channel (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic xfer_enable,
  input wire logic master_enable,
  input wire logic [3:0] src_sel,
  input wire logic cnt_load,
  input wire logic [15:0] cnt_wdata,
  // activation sources
  input wire logic [15:0] act_req,
  output logic [15:0] act_clr,
  output logic irq_pass,
  // datapath handshake
  output logic xfer_go,
  input wire logic xfer_done,
  // state
  output logic [15:0] count,
  output logic finished,
  output logic busy
);
  dbc_pkg::dbc_chan_state_t state;
  dbc_pkg::dbc_chan_state_t next_state;
  logic run;
  logic take;
  logic done;

  assign run = xfer_enable & master_enable;
  // a source still shown while its clear pulse is out is not taken twice
  assign take = (state == dbc_pkg::DBC_WAIT) & run & act_req[src_sel] &
                ~act_clr[src_sel];
  assign done = (state == dbc_pkg::DBC_XFER) & xfer_done;
  assign busy = (state != dbc_pkg::DBC_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      dbc_pkg::DBC_IDLE: begin
        if (run) begin
          next_state = dbc_pkg::DBC_WAIT;
        end
      end
      dbc_pkg::DBC_WAIT: begin
        if (!run) begin
          next_state = dbc_pkg::DBC_IDLE;
        end else if (take) begin
          next_state = dbc_pkg::DBC_XFER;
        end
      end
      dbc_pkg::DBC_XFER: begin
        if (xfer_done) begin
          next_state = dbc_pkg::DBC_WAIT;
        end
      end
      default: begin
        next_state = dbc_pkg::DBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= dbc_pkg::DBC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      xfer_go <= 1'b0;
    end else begin
      xfer_go <= take;
    end
  end

  // a software reload wins over a decrement in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      count <= dbc_pkg::COUNT_RESET;
    end else if (cnt_load) begin
      count <= cnt_wdata;
    end else if (done) begin
      count <= count - dbc_pkg::COUNT_LAST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      finished <= 1'b0;
      act_clr <= 16'h0000;
    end else begin
      finished <= done & (count == dbc_pkg::COUNT_LAST) & ~cnt_load;
      act_clr <= done ? (16'h0001 << src_sel) : 16'h0000;
    end
  end

  // disabled channel hands internal interrupt sources on to the cpu
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_pass <= 1'b0;
    end else begin
      irq_pass <= ~xfer_enable & act_req[src_sel] & dbc_pkg::INTERNAL_SRC_MASK[src_sel];
    end
  end
endmodule : dbc_channel

// [dv/dbc_band_control_monitor.sv]
// Purpose: port checks of the band control block
// Assumes: apb answers with zero wait states
// Notes: bound to every band control instance
`timescale 1ns/1ps
module dbc_band_control_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // channels
  input wire logic ch0_xfer_go,
  input wire logic ch1_xfer_go,
  input wire logic ch0_xfer_done,
  input wire logic [15:0] ch0_act_clr,
  input wire logic ch0_irq_pass,
  input wire logic ch1_irq_pass,
  input wire logic ch0_end_irq,
  input wire logic ch0_break_irq,
  input wire logic ch1_end_irq,
  input wire logic ch1_break_irq
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic setup;
  logic rd_st;
  assign setup = psel && !penable;
  assign rd_st = psel && penable && !pwrite && paddr == dbc_pkg::STATUS_ADDR;
  property p_pready;
    pready;
  endproperty
  property p_err;
    setup && paddr[7:4] != 4'h0 |=> pslverr;
  endproperty
  property p_ok;
    setup && paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  property p_st_irq;
    rd_st |-> prdata[3:0] == $past({ch1_break_irq, ch1_end_irq, ch0_break_irq, ch0_end_irq});
  endproperty
  property p_st_pass;
    rd_st |-> prdata[5:4] == $past({ch1_irq_pass, ch0_irq_pass});
  endproperty
  property p_go0;
    ch0_xfer_go |=> !ch0_xfer_go;
  endproperty
  property p_go1;
    ch1_xfer_go |=> !ch1_xfer_go;
  endproperty
  property p_clr;
    ch0_xfer_done |=> $onehot(ch0_act_clr);
  endproperty
  property p_clr_cause;
    ch0_act_clr != 16'h0000 |-> $past(ch0_xfer_done);
  endproperty
  a_pready: assert property (p_pready) else $error("pready low");
  a_err: assert property (p_err) else $error("no error on unmapped address");
  a_ok: assert property (p_ok) else $error("error on mapped address");
  a_st_irq: assert property (p_st_irq) else $error("status irq bits wrong");
  a_st_pass: assert property (p_st_pass) else $error("status pass bits wrong");
  a_go0: assert property (p_go0) else $error("ch0 start too long");
  a_go1: assert property (p_go1) else $error("ch1 start too long");
  a_clr: assert property (p_clr) else $error("no source clear");
  a_clr_cause: assert property (p_clr_cause) else $error("stray source clear");
  c_end: cover property (ch0_end_irq);
  c_brk: cover property (ch1_break_irq);
  c_pass: cover property (ch0_irq_pass);
endmodule : dbc_band_control_monitor
bind dbc_band_control dbc_band_control_monitor dbc_band_control_monitor_i (.ref_clk, .rst_b,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .ch0_xfer_go, .ch1_xfer_go,
  .ch0_xfer_done, .ch0_act_clr, .ch0_irq_pass, .ch1_irq_pass, .ch0_end_irq, .ch0_break_irq,
  .ch1_end_irq, .ch1_break_irq);

// [dv/dbc_dp_model.sv]
// Purpose: activation source and datapath of one channel
// Assumes: requests held until cleared
// Notes: LAT sets the transfer time
`timescale 1ns/1ps
module dbc_dp_model #(
  parameter int LAT = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // bench side
  input wire logic [15:0] raise,
  output int cnt,
  // block side
  input wire logic xfer_go,
  output logic xfer_done,
  input wire logic [15:0] act_clr,
  output logic [15:0] act_req
);
  int wait_n;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      act_req <= 16'h0000;
    end else begin
      act_req <= (act_req | raise) & ~act_clr;
    end
  end
  always_ff @(posedge ref_clk) begin
    xfer_done <= 1'b0;
    if (!rst_b) begin
      wait_n <= 0;
      cnt <= 0;
    end else if (xfer_go) begin
      wait_n <= LAT;
    end else if (wait_n == 1) begin
      wait_n <= 0;
      xfer_done <= 1'b1;
      cnt <= cnt + 1;
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule : dbc_dp_model

// [dv/tb.sv]
// Purpose: bench of the band control block
// Assumes: apb with zero wait states
// Notes: enabling writes follow a read
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] BC = dbc_pkg::BAND_CONTROL_ADDR;
  localparam logic [7:0] ST = dbc_pkg::STATUS_ADDR;
  localparam logic [7:0] SR = dbc_pkg::SOURCE_ADDR;
  localparam logic [7:0] CT = dbc_pkg::COUNT_ADDR;
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic nmi_evt = 1'b0, pready, pslverr, go0, go1, dn0, dn1, e0, b0, e1, b1, ps0, ps1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] rq0, rq1, clr0, clr1, r0 = 16'h0, r1 = 16'h0;
  int n0, n1, err_total = 0, checks = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  dbc_band_control dbc_band_control_i (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .act_req(rq0 | rq1), .nmi_evt,
    .ch0_xfer_go(go0), .ch0_xfer_done(dn0), .ch0_act_clr(clr0), .ch0_irq_pass(ps0),
    .ch1_xfer_go(go1), .ch1_xfer_done(dn1), .ch1_act_clr(clr1), .ch1_irq_pass(ps1),
    .ch0_end_irq(e0), .ch0_break_irq(b0), .ch1_end_irq(e1), .ch1_break_irq(b1));
  dbc_dp_model #(.LAT(1)) dbc_dp_model_i (.ref_clk, .rst_b, .raise(r0), .cnt(n0),
    .xfer_go(go0), .xfer_done(dn0), .act_clr(clr0), .act_req(rq0));
  dbc_dp_model #(.LAT(4)) dbc_dp_model_i1 (.ref_clk, .rst_b, .raise(r1), .cnt(n1),
    .xfer_go(go1), .xfer_done(dn1), .act_clr(clr1), .act_req(rq1));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // this wait ends on the first edge that sees pready high
    do begin
      @(posedge ref_clk);
    end while (!pready);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  task automatic arm(input logic [31:0] d);
    bus(1'b0, BC, 32'h0);
    bus(1'b1, BC, d);
    wt(2);
  endtask : arm
  task automatic wfor(ref int n, input int v);
    for (int k = 0; k < 100 && n < v; k++) @(posedge ref_clk);
    wt(4);
  endtask : wfor
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    wt(16);
    rst_b <= 1'b1;
    wt(1);
    bus(1'b0, BC, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk({pslverr, rd}, 33'h100000000);
    // a band write disarms what the earlier read armed
    bus(1'b1, BC, 32'h00);
    bus(1'b1, BC, 32'h10);
    bus(1'b0, BC, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, SR, 32'h03);
    bus(1'b1, CT, 32'h02);
    bus(1'b1, BC, 32'h31);
    bus(1'b0, BC, 32'h0);
    chk(rd, 32'h31);
    for (int i = 1; i <= 2; i++) begin
      r0 <= 16'h0008;
      wt(1);
      r0 <= 16'h0000;
      wfor(n0, i);
    end
    chk(n0, 32'h2);
    bus(1'b0, BC, 32'h0);
    chk(rd, 32'h21);
    bus(1'b0, ST, 32'h0);
    chk(rd, 32'h01);
    bus(1'b1, BC, 32'h20);
    wt(2);
    chk(e0, 32'h0);
    $display("test count done");
    r0 <= 16'h0008;
    wt(1);
    r0 <= 16'h0000;
    wt(3);
    chk({ps0, n0}, 33'h100000002);
    bus(1'b1, CT, 32'h01);
    arm(32'h31);
    wfor(n0, 3);
    chk({e0, ps0, n0}, 34'h200000003);
    bus(1'b1, CT, 32'h01);
    arm(32'h31);
    chk(e0, 32'h0);
    bus(1'b1, BC, 32'h21);
    wt(2);
    chk(e0, 32'h1);
    bus(1'b1, BC, 32'h02);
    wt(2);
    chk(b0, 32'h1);
    arm(32'h22);
    chk(b0, 32'h0);
    $display("test ch0 done");
    bus(1'b1, SR, 32'h53);
    bus(1'b1, CT, 32'h00010000);
    arm(32'hCC);
    r1 <= 16'h0020;
    wt(1);
    r1 <= 16'h0000;
    wfor(n1, 1);
    chk({e1, n1}, 33'h100000001);
    bus(1'b0, BC, 32'h0);
    chk(rd, 32'h8C);
    bus(1'b1, BC, 32'h88);
    wt(2);
    chk(e1, 32'h0);
    bus(1'b1, BC, 32'h08);
    wt(2);
    chk(b1, 32'h1);
    bus(1'b1, BC, 32'h00);
    wt(2);
    chk(b1, 32'h0);
    $display("test ch1 done");
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, SR, m ? 32'h100 : 32'h000);
      arm(32'h30);
      nmi_evt <= 1'b1;
      wt(1);
      nmi_evt <= 1'b0;
      wt(2);
      bus(1'b0, BC, 32'h0);
      chk(rd, m ? 32'h10 : 32'h30);
      bus(1'b1, BC, 32'h00);
    end
    $display("test nmi done");
    close_out;
  end
endmodule : tb
